// [src/psc_defines.svh]
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// Register offsets on the plain register port
`define PSC_OFF_A 4'h0
`define PSC_OFF_C 4'h1
`define PSC_OFF_R 4'h2
`define PSC_OFF_SHIFT 4'h3
`define PSC_OFF_STAT 4'h4
`define PSC_OFF_DIV 4'h5

// A register fields
`define PSC_A_SEL_HI 23
`define PSC_A_SEL_LO 22
`define PSC_A_COARSE_HI 21
`define PSC_A_COARSE_LO 6
`define PSC_A_SWALLOW_HI 5
`define PSC_A_SWALLOW_LO 0

// C register fields
`define PSC_C_OUTPUT_B_LEVEL 0
`define PSC_C_PORT 1
`define PSC_C_CUR_HI 3
`define PSC_C_CUR_LO 2

// R register fields
`define PSC_R_DIV_HI 12
`define PSC_R_DIV_LO 0

// Fixed prescaler modulus
`define PSC_PRESCALE 18'h0_0040

// Reset values
`define PSC_A_RESET 24'h00_0000
`define PSC_C_RESET 8'h00
`define PSC_R_RESET 16'h0000

`endif

// [src/psc_pkg.sv]
package psc_pkg;
  // Output A function select
  typedef enum logic [1:0] {
    PSC_OUTA_PORT = 2'h0,
    PSC_OUTA_DATA = 2'h1,
    PSC_OUTA_FV = 2'h2,
    PSC_OUTA_FR = 2'h3
  } psc_outa_t;
  // Serial load target
  typedef enum logic [1:0] {
    PSC_TGT_A = 2'h0,
    PSC_TGT_C = 2'h1,
    PSC_TGT_R = 2'h2
  } psc_tgt_t;
endpackage

// [src/psc_regs.sv]
`include "psc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module psc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic ser_data,
  input wire logic ser_clk_en,
  input wire logic ser_load,
  input wire logic divided_feedback_freq,
  input wire logic divided_reference_freq,
  output logic output_a,
  output logic output_b_level,
  output logic [6:0] phase_detector_current,
  output logic [17:0] feedback_divide,
  output logic [12:0] reference_divider
);

  // Overview
  // Three live words sit behind the pins:
  //   A holds the select, the coarse count and the swallow count
  //   C holds the output B level, the port bit and the current code
  //   R holds the reference divider in its low thirteen bits
  // Every word can arrive in two ways:
  //   As a whole word over the register port, effective next cycle
  //   Bit by bit through the shift stage, then a commit strobe
  // The commit is either the load pin or a write to the commit offset.
  //
  // Shift stage
  // Bits enter at the bottom, most significant bit first.
  // The counter tells the word apart by its length alone:
  //   8 bits go to C, 16 bits to R, 24 bits to A
  // Any other length is dropped without a trace on the live words.
  // The counter stops at 31, so a runaway frame cannot wrap to a legal length.
  // Software can read the counter before the commit to see why a frame would be dropped.
  // A commit in the same cycle as the last shift sees the old count;
  // the host must leave one cycle between them.
  //
  // Priority
  // A bus write and a serial commit to the same word in one cycle:
  // the bus write wins, since it is the later assignment.
  // A commit also clears the counter, even when the frame is dropped.
  //
  // Feedback divide
  // The total is coarse times the fixed modulus plus swallow.
  // The sum is kept at 18 bits; larger words are the host's fault
  // and wrap silently, since the counters downstream are 18 bits wide.
  // Below a total of 4032 the host must also keep coarse >= swallow;
  // nothing here checks that, the counters would just misbehave.
  // The total is registered to keep the multiplier off the output path.
  //
  // Output A
  //   00 port pin from C bit 1
  //   01 serial data out, the bit that falls off the shift stage
  //   10 divided feedback clock
  //   11 divided reference clock
  // The two clocks pass straight through; a flop would cost a cycle of skew.
  // Serial out is taken from a flop so that the pin does not glitch
  // while the shift stage moves.
  // In a chain only the last device should leave the data-out setting.
  //
  // Pump current
  // The code in C bits 3:2 is read against two tables, picked by whether
  // output A is a port. The result is a plain percentage in binary.
  // The table switches as soon as the select changes, with no C write.
  //
  // Read back
  // Read data appear in the cycle after the strobe and only there;
  // in every other cycle they are zero, so a stale word cannot be taken.
  // Unmapped offsets read as zero and ignore writes.
  //
  // Reset
  // Synchronous and active low. All words clear, which leaves output A
  // as a port pin driven low and the current at the port table's lowest step.

  // Live registers; only ever updated by a complete load
  logic [23:0] reg_a;
  logic [7:0] reg_c;
  logic [15:0] reg_r;
  // Shift stage; partial contents never reach the live registers
  logic [23:0] shift_q;
  logic [4:0] shift_cnt;
  logic serial_out_q;
  logic [12:0] ref_div_q;
  logic [17:0] fb_div_q;

  // Percent table for the current field
  function automatic logic [6:0] psc_current(input logic port_mode, input logic [1:0] code);
    logic [6:0] pct;
    pct = 7'h64;
    if (port_mode) begin
      unique case (code)
        2'h0: pct = 7'h46;
        2'h1: pct = 7'h50;
        2'h2: pct = 7'h5a;
        2'h3: pct = 7'h64;
      endcase
    end else begin
      unique case (code)
        2'h0: pct = 7'h19;
        2'h1: pct = 7'h32;
        2'h2: pct = 7'h4b;
        2'h3: pct = 7'h64;
      endcase
    end
    return pct;
  endfunction

  // Field decode
  wire [15:0] coarse_count = reg_a[`PSC_A_COARSE_HI:`PSC_A_COARSE_LO];
  wire [5:0] swallow_count = reg_a[`PSC_A_SWALLOW_HI:`PSC_A_SWALLOW_LO];
  wire [1:0] outa_sel = reg_a[`PSC_A_SEL_HI:`PSC_A_SEL_LO];
  wire port_mode = (outa_sel == psc_pkg::PSC_OUTA_PORT);
  // Product kept at 18 bits; host never exceeds that range
  wire [17:0] next_fb_div = 18'(18'(coarse_count) * `PSC_PRESCALE) + 18'(swallow_count);

  // Register bus decode
  wire wr_a = wr && (addr == `PSC_OFF_A);
  wire wr_c = wr && (addr == `PSC_OFF_C);
  wire wr_r = wr && (addr == `PSC_OFF_R);
  wire wr_shift = wr && (addr == `PSC_OFF_SHIFT);

  // Direct loads or serial shift; a complete word only updates on load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_a <= `PSC_A_RESET;
      reg_c <= `PSC_C_RESET;
      reg_r <= `PSC_R_RESET;
      shift_q <= 24'h00_0000;
      shift_cnt <= 5'h00;
    end else begin
      if (ser_clk_en) begin
        shift_q <= {shift_q[22:0], ser_data};
        shift_cnt <= (shift_cnt == 5'h1f) ? shift_cnt : shift_cnt + 5'h01;
      end
      if (ser_load || wr_shift) begin
        shift_cnt <= 5'h00;
        if (shift_cnt == 5'h18)
          reg_a <= shift_q;
        else if (shift_cnt == 5'h08)
          reg_c <= shift_q[7:0];
        else if (shift_cnt == 5'h10)
          reg_r <= shift_q[15:0];
      end
      if (wr_a) reg_a <= wdata[23:0];
      if (wr_c) reg_c <= wdata[7:0];
      if (wr_r) reg_r <= wdata[15:0];
    end
  end

  // Serial out carries the last bit shifted through
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_out_q <= 1'b0;
      fb_div_q <= 18'h0_0000;
      ref_div_q <= 13'h0000;
    end else begin
      serial_out_q <= shift_q[23];
      fb_div_q <= next_fb_div;
      ref_div_q <= reg_r[`PSC_R_DIV_HI:`PSC_R_DIV_LO];
    end
  end

  // Output A mux; divided clocks pass combinationally to avoid a cycle of skew
  always_comb begin
    unique case (outa_sel)
      psc_pkg::PSC_OUTA_PORT: output_a = reg_c[`PSC_C_PORT];
      psc_pkg::PSC_OUTA_DATA: output_a = serial_out_q;
      psc_pkg::PSC_OUTA_FV: output_a = divided_feedback_freq;
      psc_pkg::PSC_OUTA_FR: output_a = divided_reference_freq;
    endcase
  end

  assign output_b_level = reg_c[`PSC_C_OUTPUT_B_LEVEL];
  assign phase_detector_current = psc_current(port_mode, reg_c[`PSC_C_CUR_HI:`PSC_C_CUR_LO]);
  assign feedback_divide = fb_div_q;
  assign reference_divider = ref_div_q;

  // Read back: live registers, shift count, divide
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        `PSC_OFF_A: rdata <= {8'h00, reg_a};
        `PSC_OFF_C: rdata <= {24'h00_0000, reg_c};
        `PSC_OFF_R: rdata <= {16'h0000, reg_r};
        `PSC_OFF_STAT: rdata <= {27'h000_0000, shift_cnt};
        `PSC_OFF_DIV: rdata <= {14'h0000, fb_div_q};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// [tb/psc_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module psc_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic divided_feedback_freq,
  input wire logic divided_reference_freq,
  input wire logic output_a,
  input wire logic output_b_level,
  input wire logic [6:0] phase_detector_current,
  input wire logic [17:0] feedback_divide
);
  logic [1:0] sel;
  // Select mirror; bus writes only, so serial loads of A are not followed
  always_ff @(posedge clk)
    sel <= !rst_n ? 2'h0 : (wr && addr == 4'h0) ? wdata[23:22] : sel;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence a_wr;
    wr && addr == 4'h0;
  endsequence
  fdiv_calc_a:
    assert property (a_wr |=> ##1 feedback_divide ==
      18'($past(wdata[21:6], 2) * 64 + $past(wdata[5:0], 2))) else $error("divide");
  output_b_level_write_a:
    assert property (wr && addr == 4'h1 |=> output_b_level == $past(wdata[0])) else $error("B");
  fv_route_a:
    assert property (sel == 2'h2 |-> output_a == divided_feedback_freq) else $error("fv");
  fr_route_a:
    assert property (sel == 2'h3 |-> output_a == divided_reference_freq) else $error("fr");
  port_cur_a:
    assert property (sel == 2'h0 |-> phase_detector_current inside {7'h46, 7'h50, 7'h5a, 7'h64})
      else $error("port current");
  other_cur_a:
    assert property (sel != 2'h0 |-> phase_detector_current inside {7'h19, 7'h32, 7'h4b, 7'h64})
      else $error("current");
  port_pin_a:
    assert property (wr && addr == 4'h1 && sel == 2'h0 |=> output_a == $past(wdata[1]))
      else $error("port pin");
  read_idle_a:
    assert property (!rd |=> rdata == 32'h0) else $error("read data");
endmodule
bind psc_regs psc_regs_chk chk (.*);
`default_nettype wire

// [tb/psc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module psc_host (
  input wire logic clk,
  output logic ser_data,
  output logic ser_clk_en,
  output logic ser_load
);
  // Idle link at time zero
  initial begin
    ser_data = 1'h0;
    ser_clk_en = 1'h0;
    ser_load = 1'h0;
  end
  // Whole word MSB first, commit only after the last bit
  task automatic send(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      ser_clk_en <= 1'h1;
      ser_data <= w[i];
    end
    @(posedge clk);
    ser_clk_en <= 1'h0;
    ser_data <= ~w[0]; // Released line must not look valid
    ser_load <= 1'h1;
    @(posedge clk);
    ser_load <= 1'h0;
  endtask
endmodule
`default_nettype wire

// [tb/psc_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module psc_regs_tb_top;
  logic clk, rst_n, wr, rd, dfb, dref;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [6:0] cur;
  logic [17:0] fdiv;
  logic [12:0] rdiv;
  wire sd, sce, sld, oa, ob;
  int failures = 0;
  int samples_checked = 0;
  logic [6:0] pct [8] = '{7'h46, 7'h50, 7'h5a, 7'h64, 7'h19, 7'h32, 7'h4b, 7'h64};
  psc_regs dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ser_data(sd),
    .ser_clk_en(sce), .ser_load(sld), .divided_feedback_freq(dfb),
    .divided_reference_freq(dref), .output_a(oa), .output_b_level(ob),
    .phase_detector_current(cur), .feedback_divide(fdiv), .reference_divider(rdiv));
  psc_host host (.clk, .ser_data(sd), .ser_clk_en(sce), .ser_load(sld));
  // 250 MHz clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; read data is sampled in the cycle after it
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1;
  endtask
  task automatic w2;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_div;
    bus(1'h1, 4'h0, 32'h3_ffff);
    w2();
    chk(32'(fdiv), 32'h3_ffff);
    bus(1'h0, 4'h0, 32'h0);
    chk(rdata, 32'h3_ffff);
    bus(1'h1, 4'h1, 32'h1);
    w2();
    chk(32'(ob), 32'h1);
    bus(1'h0, 4'hf, 32'h0);
    chk(rdata, 32'h0);
  endtask
  // Bit 7 of each C frame carries c[1], so data out shows the frame two back
  task automatic t_modes;
    for (int s = 0; s < 4; s++) begin
      // Single device on the chain, so it is the last one
      bus(1'h1, 4'h0, {8'h0, 2'(s), 22'hfff});
      for (int c = 0; c < 4; c++) begin
        logic exp_a;
        dfb <= c[0];
        dref <= !c[0];
        host.send({16'h0, c[1], 3'h0, 2'(c), 1'h1, c[0]}, 8);
        w2();
        chk(32'(cur), 32'(pct[(s > 0) * 4 + c]));
        exp_a = (s == 0) ? 1'h1 : (s == 1) ? (c < 2) : (c[0] ^ (s == 3));
        chk(32'(oa), 32'(exp_a));
      end
    end
  endtask
  // R first, then A on the new spacing, then a short frame that must be dropped
  task automatic t_ser;
    host.send(24'h1ffe, 16);
    bus(1'h0, 4'h2, 32'h0);
    chk(rdata, 32'h1ffe);
    chk(32'(rdiv), 32'h1ffe);
    bus(1'h1, 4'h0, 32'h0fc0);
    bus(1'h0, 4'h5, 32'h0);
    chk(rdata, 32'h0fc0);
    host.send(24'h0, 5);
    w2();
    chk(32'(cur), 32'h64);
    bus(1'h0, 4'h4, 32'h0);
    chk(rdata, 32'h0);
  endtask
  task automatic end_sim;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst_n, wr, rd, dfb, dref, addr, wdata} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_div();
    t_modes();
    t_ser();
    end_sim();
  end
  // Run needs well under a thousand cycles
  initial begin
    #20000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
